// file: core/urd_pkg.sv
// package for the rate divider and transmit holding block
// holds register offsets, field positions, reset values and divider ratios
package urd_pkg;

   // ------------------------------------------------------------
   // register offsets on the plain register port
   // ------------------------------------------------------------
   localparam logic [3:0] URD_OFF_HOLDING = 4'h0;
   localparam logic [3:0] URD_OFF_DIV_LOW = 4'h1;
   localparam logic [3:0] URD_OFF_DIV_HIGH = 4'h2;
   localparam logic [3:0] URD_OFF_TX_CTRL = 4'h3;
   localparam logic [3:0] URD_OFF_RATE_CTRL = 4'h4;
   localparam logic [3:0] URD_OFF_IRQ_STATUS = 4'h5;
   localparam logic [3:0] URD_OFF_IRQ_MASK = 4'h6;

   // ------------------------------------------------------------
   // transmit control and status field positions
   // ------------------------------------------------------------
   localparam int URD_TX_CLOCK_SOURCE = 7;
   localparam int URD_TX_NINE_BIT = 6;
   localparam int URD_TX_ENABLE = 5;
   localparam int URD_TX_CLOCKED = 4;
   localparam int URD_TX_BREAK = 3;
   localparam int URD_TX_FAST = 2;
   localparam int URD_TX_SHIFT_EMPTY = 1;
   localparam int URD_TX_NINTH = 0;

   // ------------------------------------------------------------
   // rate control field positions
   // ------------------------------------------------------------
   localparam int URD_RC_AUTOBAUD_OVF = 7;
   localparam int URD_RC_RECEIVE_IDLE = 6;
   localparam int URD_RC_CLOCK_POLARITY = 4;
   localparam int URD_RC_WIDE_DIVISOR = 3;
   localparam int URD_RC_WAKE_ON_EDGE = 1;
   localparam int URD_RC_AUTOBAUD_EN = 0;
   localparam logic [7:0] URD_RC_WRITE_MASK = 8'h9b;

   // ------------------------------------------------------------
   // interrupt status fields
   // ------------------------------------------------------------
   localparam int URD_IRQ_HOLDING_EMPTY = 0;
   localparam int URD_IRQ_SHIFT_DONE = 1;
   localparam logic [7:0] URD_IRQ_USED_MASK = 8'h03;

   // ------------------------------------------------------------
   // reset values
   // ------------------------------------------------------------
   localparam logic [7:0] URD_RST_BYTE = 8'h00;
   localparam logic [7:0] URD_RST_TX_CTRL = 8'h02;
   localparam logic [7:0] URD_RST_RATE_CTRL = 8'h00;

   // ------------------------------------------------------------
   // divider prescale ratios, stored as ratio minus one
   // ------------------------------------------------------------
   localparam logic [5:0] URD_PRE_64 = 6'h3f;
   localparam logic [5:0] URD_PRE_16 = 6'h0f;
   localparam logic [5:0] URD_PRE_4 = 6'h03;

   // ------------------------------------------------------------
   // frame counts in bit times
   // ------------------------------------------------------------
   localparam logic [3:0] URD_BITS_EIGHT = 4'h8;
   localparam logic [3:0] URD_BITS_NINE = 4'h9;
   localparam logic [3:0] URD_BREAK_ZEROS = 4'hc;

   typedef enum logic [2:0] {
      URD_IDLE,
      URD_START,
      URD_DATA,
      URD_STOP,
      URD_BREAK
   } urd_tx_state_t;

endpackage

// file: core/urd_rate_if.sv
// carrier between the register block and the rate generator
// assumes both ends share clk and reset_n
`timescale 1ns/100ps
interface urd_rate_if;
   logic [15:0] divisor;
   logic [5:0] prescale;
   logic restart;
   logic tick;

   modport gen
   (
      input divisor,
      input prescale,
      input restart,
      output tick
   );

   modport user
   (
      output divisor,
      output prescale,
      output restart,
      input tick
   );
endinterface

// file: core/urd_rate_gen.sv
// rate generator: one tick every (prescale+1)*(divisor+1) clocks
// assumes divisor and prescale are stable except around a restart
`timescale 1ns/100ps
module urd_rate_gen
   import urd_pkg::*;
(
   input wire logic clk,
   input wire logic reset_n,
   urd_rate_if.gen rate
);

   logic [15:0] div_cnt_reg;
   logic [15:0] div_cnt_next;
   logic [5:0] pre_cnt_reg;
   logic [5:0] pre_cnt_next;
   logic tick_reg;
   logic tick_next;

   // prescaler counts down inside each divisor step; the divisor
   // counts down once per prescale wrap, so the ratio is the product
   always_comb
   begin
      div_cnt_next = div_cnt_reg;
      pre_cnt_next = pre_cnt_reg;
      tick_next = 1'b0;
      if (rate.restart)
      begin
         div_cnt_next = rate.divisor;
         pre_cnt_next = rate.prescale;
      end
      else if (pre_cnt_reg != 6'h00)
         pre_cnt_next = pre_cnt_reg - 6'h01;
      else
      begin
         pre_cnt_next = rate.prescale;
         if (div_cnt_reg != 16'h0000)
            div_cnt_next = div_cnt_reg - 16'h0001;
         else
         begin
            div_cnt_next = rate.divisor;
            tick_next = 1'b1;
         end
      end
   end

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         div_cnt_reg <= 16'h0000;
         pre_cnt_reg <= 6'h00;
         tick_reg <= 1'b0;
      end
      else
      begin
         div_cnt_reg <= div_cnt_next;
         pre_cnt_reg <= pre_cnt_next;
         tick_reg <= tick_next;
      end
   end

   assign rate.tick = tick_reg;

endmodule

// file: core/urd_top.sv
// rate divider and double-buffered transmit holding byte with shifter
// assumes a plain register port synchronous to clk and one clock domain
//
// What this block does
// - holding byte plus ninth bit double buffered
// - low divisor write restarts generator counter
// - high divisor write restarts generator counter
// - high byte ignored unless wide divisor set
// - divisor is high byte over low byte
// - async narrow slow: clock over 64(n+1)
// - async wide slow: clock over 16(n+1)
// - synchronous: clock over 4(n+1)
// - transmit control and status bit layout
// - rate control bit layout, unused read zero
`timescale 1ns/100ps
module urd_top
   import urd_pkg::*;
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [3:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [7:0] reg_rdata,
   input wire logic receive_idle_in,
   output logic tx_line,
   output logic bit_tick,
   output logic irq
);

   // ------------------------------------------------------------
   // register state
   // ------------------------------------------------------------
   logic [7:0] holding_reg;
   logic [7:0] holding_next;
   logic holding_full_reg;
   logic holding_full_next;
   logic [7:0] div_low_reg;
   logic [7:0] div_low_next;
   logic [7:0] div_high_reg;
   logic [7:0] div_high_next;
   logic [7:0] tx_ctrl_reg;
   logic [7:0] tx_ctrl_next;
   logic [7:0] rate_ctrl_reg;
   logic [7:0] rate_ctrl_next;
   logic [7:0] irq_status_reg;
   logic [7:0] irq_status_next;
   logic [7:0] irq_mask_reg;
   logic [7:0] irq_mask_next;
   logic [7:0] rdata_reg;
   logic [7:0] rdata_next;
   logic irq_reg;
   logic irq_next;
   logic idle_sync_reg;

   // ------------------------------------------------------------
   // shifter state
   // ------------------------------------------------------------
   urd_tx_state_t state_reg;
   urd_tx_state_t state_next;
   logic [8:0] shift_reg;
   logic [8:0] shift_next;
   logic [3:0] bits_left_reg;
   logic [3:0] bits_left_next;
   logic line_reg;
   logic line_next;
   logic tick_out_reg;
   logic tx_out_reg;
   logic tx_out_next;

   // ------------------------------------------------------------
   // decoded controls
   // ------------------------------------------------------------
   logic wr_holding;
   logic wr_div_low;
   logic wr_div_high;
   logic load_shifter;
   logic shift_done;
   logic clocked_mode;
   logic nine_bit;
   logic tx_enable;
   logic break_req;
   logic wide_div;
   logic fast_rate;
   logic tick;

   urd_rate_if rate ();

   urd_rate_gen u_rate_gen
   (
      .clk(clk),
      .reset_n(reset_n),
      .rate(rate)
   );

   assign tick = rate.tick;
   assign clocked_mode = tx_ctrl_reg[URD_TX_CLOCKED];
   assign nine_bit = tx_ctrl_reg[URD_TX_NINE_BIT];
   assign tx_enable = tx_ctrl_reg[URD_TX_ENABLE];
   assign break_req = tx_ctrl_reg[URD_TX_BREAK];
   assign fast_rate = tx_ctrl_reg[URD_TX_FAST];
   assign wide_div = rate_ctrl_reg[URD_RC_WIDE_DIVISOR];

   // write decode; each write to either divisor byte restarts the count
   assign wr_holding = reg_write && (reg_addr == URD_OFF_HOLDING);
   assign wr_div_low = reg_write && (reg_addr == URD_OFF_DIV_LOW);
   assign wr_div_high = reg_write && (reg_addr == URD_OFF_DIV_HIGH);
   assign rate.restart = wr_div_low || wr_div_high;

   // ------------------------------------------------------------
   // divisor and prescale selection
   // ------------------------------------------------------------
   // the high byte only reaches the generator in wide mode
   assign rate.divisor = wide_div ? {div_high_next, div_low_next}
                                  : {8'h00, div_low_next};

   // pick the fixed ratio from the three mode bits
   always_comb
   begin
      if (clocked_mode)
         rate.prescale = URD_PRE_4;
      else if (!wide_div && !fast_rate)
         rate.prescale = URD_PRE_64;
      else if (wide_div && !fast_rate)
         rate.prescale = URD_PRE_16;
      else if (!wide_div)
         rate.prescale = URD_PRE_16;
      else
         rate.prescale = URD_PRE_4;
   end

   // ------------------------------------------------------------
   // transmit shifter
   // ------------------------------------------------------------
   // the holding byte moves into the shifter as soon as the shifter is
   // idle and transmit is enabled, which frees the holding register for the next byte
   assign load_shifter = (state_reg == URD_IDLE) && holding_full_reg && tx_enable;

   always_comb
   begin
      state_next = state_reg;
      shift_next = shift_reg;
      bits_left_next = bits_left_reg;
      line_next = line_reg;
      shift_done = 1'b0;
      unique case (state_reg)
         URD_IDLE:
         begin
            line_next = 1'b1;
            if (load_shifter)
            begin
               shift_next = {tx_ctrl_reg[URD_TX_NINTH], holding_reg};
               bits_left_next = nine_bit ? URD_BITS_NINE : URD_BITS_EIGHT;
               if (clocked_mode)
                  state_next = URD_DATA;
               else if (break_req)
               begin
                  // a break replaces the byte with a long run of zeros
                  state_next = URD_BREAK;
                  bits_left_next = URD_BREAK_ZEROS;
               end
               else
                  state_next = URD_START;
            end
         end
         URD_START:
            if (tick)
            begin
               line_next = 1'b0;
               state_next = URD_DATA;
            end
         URD_DATA:
            if (tick)
            begin
               line_next = shift_reg[0];
               shift_next = {1'b0, shift_reg[8:1]};
               bits_left_next = bits_left_reg - 4'h1;
               if (bits_left_reg == 4'h1)
                  state_next = URD_STOP;
            end
         URD_BREAK:
            if (tick)
            begin
               line_next = 1'b0;
               bits_left_next = bits_left_reg - 4'h1;
               if (bits_left_reg == 4'h1)
                  state_next = URD_STOP;
            end
         URD_STOP:
            if (tick)
            begin
               // both modes end here; on the tick the line returns high and the shifter idles
               line_next = 1'b1;
               state_next = URD_IDLE;
               shift_done = 1'b1;
            end
         default:
            state_next = URD_IDLE;
      endcase
      if (!tx_enable)
      begin
         // dropping the enable aborts the frame and idles the line
         state_next = URD_IDLE;
         line_next = 1'b1;
      end
   end

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         state_reg <= URD_IDLE;
         shift_reg <= 9'h000;
         bits_left_reg <= 4'h0;
         line_reg <= 1'b1;
         tick_out_reg <= 1'b0;
         tx_out_reg <= 1'b1;
      end
      else
      begin
         state_reg <= state_next;
         shift_reg <= shift_next;
         bits_left_reg <= bits_left_next;
         line_reg <= line_next;
         tick_out_reg <= tick;
         tx_out_reg <= tx_out_next;
      end
   end

   // ------------------------------------------------------------
   // register writes and hardware-owned bits
   // ------------------------------------------------------------
   always_comb
   begin
      holding_next = holding_reg;
      holding_full_next = holding_full_reg;
      div_low_next = div_low_reg;
      div_high_next = div_high_reg;
      tx_ctrl_next = tx_ctrl_reg;
      rate_ctrl_next = rate_ctrl_reg;
      irq_mask_next = irq_mask_reg;
      irq_status_next = irq_status_reg;
      if (load_shifter)
         holding_full_next = 1'b0;
      if (wr_holding)
      begin
         holding_next = reg_wdata;
         holding_full_next = 1'b1;
      end
      if (wr_div_low)
         div_low_next = reg_wdata;
      if (wr_div_high)
         div_high_next = reg_wdata;
      if (reg_write && (reg_addr == URD_OFF_TX_CTRL))
      begin
         // shift-empty is read-only and keeps its hardware value
         tx_ctrl_next = reg_wdata;
         tx_ctrl_next[URD_TX_SHIFT_EMPTY] = tx_ctrl_reg[URD_TX_SHIFT_EMPTY];
      end
      if (reg_write && (reg_addr == URD_OFF_RATE_CTRL))
      begin
         rate_ctrl_next = reg_wdata & URD_RC_WRITE_MASK;
         rate_ctrl_next[URD_RC_RECEIVE_IDLE] = idle_sync_reg;
      end
      else
         rate_ctrl_next[URD_RC_RECEIVE_IDLE] = idle_sync_reg;
      // break request clears itself once its frame has gone out
      if (shift_done && (state_reg == URD_STOP) && break_req && !clocked_mode)
         tx_ctrl_next[URD_TX_BREAK] = 1'b0;
      tx_ctrl_next[URD_TX_SHIFT_EMPTY] = (state_next == URD_IDLE);
      if (reg_write && (reg_addr == URD_OFF_IRQ_MASK))
         irq_mask_next = reg_wdata & URD_IRQ_USED_MASK;
      // write one to clear, applied before the sets so an event wins
      if (reg_write && (reg_addr == URD_OFF_IRQ_STATUS))
         irq_status_next = irq_status_reg & ~reg_wdata;
      if (load_shifter)
         irq_status_next[URD_IRQ_HOLDING_EMPTY] = 1'b1;
      if (shift_done)
         irq_status_next[URD_IRQ_SHIFT_DONE] = 1'b1;
      irq_next = |(irq_status_next & irq_mask_next);
   end

   // ------------------------------------------------------------
   // read path: data stands in the cycle after the strobe
   // ------------------------------------------------------------
   always_comb
   begin
      rdata_next = 8'h00;
      if (reg_read)
      begin
         unique case (reg_addr)
            URD_OFF_HOLDING: rdata_next = holding_reg;
            URD_OFF_DIV_LOW: rdata_next = div_low_reg;
            URD_OFF_DIV_HIGH: rdata_next = div_high_reg;
            URD_OFF_TX_CTRL: rdata_next = tx_ctrl_reg;
            URD_OFF_RATE_CTRL: rdata_next = rate_ctrl_reg;
            URD_OFF_IRQ_STATUS: rdata_next = irq_status_reg;
            URD_OFF_IRQ_MASK: rdata_next = irq_mask_reg;
            default: rdata_next = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         holding_reg <= URD_RST_BYTE;
         holding_full_reg <= 1'b0;
         div_low_reg <= URD_RST_BYTE;
         div_high_reg <= URD_RST_BYTE;
         tx_ctrl_reg <= URD_RST_TX_CTRL;
         rate_ctrl_reg <= URD_RST_RATE_CTRL;
         irq_status_reg <= URD_RST_BYTE;
         irq_mask_reg <= URD_RST_BYTE;
         rdata_reg <= URD_RST_BYTE;
         irq_reg <= 1'b0;
         idle_sync_reg <= 1'b0;
      end
      else
      begin
         holding_reg <= holding_next;
         holding_full_reg <= holding_full_next;
         div_low_reg <= div_low_next;
         div_high_reg <= div_high_next;
         tx_ctrl_reg <= tx_ctrl_next;
         rate_ctrl_reg <= rate_ctrl_next;
         irq_status_reg <= irq_status_next;
         irq_mask_reg <= irq_mask_next;
         rdata_reg <= rdata_next;
         irq_reg <= irq_next;
         idle_sync_reg <= receive_idle_in;
      end
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   // polarity select inverts the asynchronous line; a limitation is
   // that the inverted line idles low, as a far end expecting it must
   assign tx_out_next = line_next
      ^ (rate_ctrl_next[URD_RC_CLOCK_POLARITY] && !tx_ctrl_next[URD_TX_CLOCKED]);
   assign tx_line = tx_out_reg;
   assign reg_rdata = rdata_reg;
   assign bit_tick = tick_out_reg;
   assign irq = irq_reg;

endmodule

// file: tb/urd_top_props.sv
// checker for the rate divider and transmit holding block
// assumes it sees only the top ports, one clock domain, reset_n active low
`timescale 1ns/100ps
module urd_top_props
   import urd_pkg::*;
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [3:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   input wire logic [7:0] reg_rdata,
   input wire logic receive_idle_in,
   input wire logic tx_line,
   input wire logic bit_tick,
   input wire logic irq
);
   logic [7:0] lo_reg, lo_next, hi_reg, hi_next, tc_reg, tc_next, rc_reg, rc_next;
   logic [23:0] cnt_reg, cnt_next, per;
   logic [15:0] n16;
   logic [6:0] pre;
   logic valid_reg, valid_next, cfg_wr, wide, fast, clocked;

   // ------------------------------------------------------------
   // shadow of the rate settings and a tick interval counter
   // ------------------------------------------------------------
   assign cfg_wr = reg_write && reg_addr >= URD_OFF_DIV_LOW && reg_addr <= URD_OFF_RATE_CTRL;
   assign wide = rc_reg[URD_RC_WIDE_DIVISOR];
   assign fast = tc_reg[URD_TX_FAST];
   assign clocked = tc_reg[URD_TX_CLOCKED];

   // an interval is judged only if no setting changed since the tick opening it
   always_comb
   begin
      lo_next = lo_reg;
      hi_next = hi_reg;
      tc_next = tc_reg;
      rc_next = rc_reg;
      if (reg_write && reg_addr == URD_OFF_DIV_LOW)
         lo_next = reg_wdata;
      if (reg_write && reg_addr == URD_OFF_DIV_HIGH)
         hi_next = reg_wdata;
      if (reg_write && reg_addr == URD_OFF_TX_CTRL)
         tc_next = reg_wdata;
      if (reg_write && reg_addr == URD_OFF_RATE_CTRL)
         rc_next = reg_wdata;
      cnt_next = bit_tick ? 24'h000000 : cnt_reg + 24'h000001;
      valid_next = (bit_tick || valid_reg) && !cfg_wr;
   end

   // expected period from mode bits and divisor
   always_comb
   begin
      if (clocked || (wide && fast))
         pre = 7'h04;
      else if (wide || fast)
         pre = 7'h10;
      else
         pre = 7'h40;
      n16 = wide ? {hi_reg, lo_reg} : {8'h00, lo_reg};
      per = 24'(pre) * (24'(n16) + 24'h000001);
   end

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         {lo_reg, hi_reg, tc_reg, rc_reg} <= 32'h00000000;
         cnt_reg <= 24'h000000;
         valid_reg <= 1'b0;
      end
      else
      begin
         {lo_reg, hi_reg, tc_reg, rc_reg} <= {lo_next, hi_next, tc_next, rc_next};
         cnt_reg <= cnt_next;
         valid_reg <= valid_next;
      end
   end

   // ------------------------------------------------------------
   // properties
   // ------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   sequence s_quiet3;
      !bit_tick [*3];
   endsequence

   AST_RATE_NARROW_SLOW: assert property (
      bit_tick && valid_reg && !clocked && !wide && !fast |-> cnt_reg + 24'h1 == per)
      else $error("narrow slow tick period wrong");
   AST_RATE_WIDE_SLOW: assert property (
      bit_tick && valid_reg && !clocked && wide && !fast |-> cnt_reg + 24'h1 == per)
      else $error("wide slow tick period wrong");
   AST_RATE_CLOCKED: assert property (
      bit_tick && valid_reg && clocked |-> cnt_reg + 24'h1 == per)
      else $error("clocked mode tick period wrong");
   AST_RATE_FAST: assert property (
      bit_tick && valid_reg && !clocked && fast |-> cnt_reg + 24'h1 == per)
      else $error("fast select tick period wrong");
   AST_HIGH_IGNORED: assert property (
      bit_tick && valid_reg && !wide |-> cnt_reg + 24'h1 == 24'(pre) * (24'(lo_reg) + 24'h1))
      else $error("high divisor byte used while narrow");
   AST_WIDE_PAIR: assert property (
      bit_tick && valid_reg && wide |-> cnt_reg + 24'h1 == per)
      else $error("wide divisor pairing wrong");
   AST_RESTART_LOW: assert property (
      reg_write && reg_addr == URD_OFF_DIV_LOW |=> ##1 s_quiet3)
      else $error("tick too soon after low divisor write");
   AST_RESTART_HIGH: assert property (
      reg_write && reg_addr == URD_OFF_DIV_HIGH |=> ##1 s_quiet3)
      else $error("tick too soon after high divisor write");
   AST_UNUSED_ZERO: assert property (
      reg_read && reg_addr == URD_OFF_RATE_CTRL |=> reg_rdata[5] == 1'b0 && reg_rdata[2] == 1'b0)
      else $error("unused rate control bits not zero");
   AST_RDATA_QUIET: assert property (!reg_read |=> reg_rdata == 8'h00)
      else $error("read data not zero outside a read");
   AST_TICK_PULSE: assert property ($rose(bit_tick) |=> $fell(bit_tick))
      else $error("bit tick longer than one cycle");
   AST_IRQ_MASKED: assert property (
      reg_write && reg_addr == URD_OFF_IRQ_MASK && reg_wdata == 8'h00 |=> ##1 !irq)
      else $error("interrupt high with mask cleared");
endmodule

bind urd_top urd_top_props props_i (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
   .receive_idle_in(receive_idle_in), .tx_line(tx_line), .bit_tick(bit_tick), .irq(irq));

// file: tb/urd_serial_peer.sv
// far side receiver: collects asynchronous frames from the serial line
// assumes line levels change at bit ticks and hold one tick period (at least 16 clocks)
`timescale 1ns/100ps
module urd_serial_peer
(
   input wire logic clk,
   input wire logic line,
   input wire logic tick,
   input wire logic nine
);
   logic [1:0] dly = 2'b00;
   logic busy = 1'b0;
   logic [3:0] idx = 4'h0;
   logic [8:0] sh = 9'h000;
   logic [8:0] got [$];

   // sample two clocks after each tick so the level has settled
   always @(posedge clk)
   begin
      dly <= {dly[0], tick};
      if (dly[1])
      begin
         if (!busy)
         begin
            busy <= (line === 1'b0);
            idx <= 4'h0;
         end
         else if (idx < (nine ? 4'h9 : 4'h8))
         begin
            sh[idx] <= line;
            idx <= idx + 4'h1;
         end
         else
         begin
            busy <= 1'b0;
            if (line === 1'b1)
               got.push_back(sh & (nine ? 9'h1ff : 9'h0ff));
         end
      end
   end
endmodule

// file: tb/tb.sv
// self-checking bench for the rate divider and transmit holding block
// assumes the checker is bound in and the peer collects frames on the line
`timescale 1ns/100ps
module tb;
   import urd_pkg::*;
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic [3:0] reg_addr = 4'h0;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_write = 1'b0, reg_read = 1'b0, receive_idle_in = 1'b0, nine = 1'b0;
   logic [7:0] reg_rdata, rd_val;
   logic tx_line, bit_tick, irq;
   int mismatches = 0, checks_done = 0, gap;
   // register rows: write flag, index, write data, expected read
   logic [20:0] reg_rows [16] = '{21'h000000, 21'h010000, 21'h020000, 21'h030002,
      21'h040000, 21'h050000, 21'h060000, 21'h070000, 21'h11a5a5, 21'h123c3c, 21'h10a5a5,
      21'h14ff9b, 21'h13dddf, 21'h175500, 21'h16ff03, 21'h130002};
   // rate rows: control, rate control, low, high, expected period in clocks
   logic [47:0] rate_rows [6] = '{48'h000002050_0c0, 48'h000802011030, 48'h040002050030,
      48'h040803000010, 48'h100004050014, 48'h140801010408};

   always #25 clk = ~clk;

   urd_top dut (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
      .receive_idle_in(receive_idle_in), .tx_line(tx_line), .bit_tick(bit_tick), .irq(irq));
   urd_serial_peer peer (.clk(clk), .line(tx_line), .tick(bit_tick), .nine(nine));

   // ------------------------------------------------------------
   // bus, wait and compare tasks
   // ------------------------------------------------------------
   task wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge clk);
      reg_write <= 1'b0;
   endtask

   // read data stand only in the cycle after the strobe edge
   task rd(input logic [3:0] a);
      @(posedge clk);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge clk);
      reg_read <= 1'b0;
      #1;
      rd_val = reg_rdata;
   endtask

   task wait_tick(output int c);
      c = 0;
      do
      begin
         @(posedge clk);
         #1;
         c++;
      end
      while (bit_tick !== 1'b1 && c < 20000);
   endtask

   task check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task tally_and_finish;
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial
   begin
      repeat (16) @(posedge clk);
      reset_n <= 1'b1;
      foreach (reg_rows[i])
      begin
         if (reg_rows[i][20])
            wr(reg_rows[i][19:16], reg_rows[i][15:8]);
         rd(reg_rows[i][19:16]);
         check("register", {8'h00, rd_val}, {8'h00, reg_rows[i][7:0]});
      end
      receive_idle_in <= 1'b1;
      repeat (3) @(posedge clk);
      rd(URD_OFF_RATE_CTRL);
      check("receive idle", {8'h00, rd_val}, 16'h00db);
      // the tick after a restart is irregular, so the second gap is measured
      foreach (rate_rows[i])
      begin
         wr(URD_OFF_TX_CTRL, rate_rows[i][47:40]);
         wr(URD_OFF_RATE_CTRL, rate_rows[i][39:32]);
         wr(URD_OFF_DIV_LOW, rate_rows[i][31:24]);
         wr(URD_OFF_DIV_HIGH, rate_rows[i][23:16]);
         repeat (2) @(posedge clk);
         wait_tick(gap);
         wait_tick(gap);
         check("tick period", 16'(gap), rate_rows[i][15:0]);
      end
      // mid-interval divisor writes push the next tick a full period out
      wr(URD_OFF_TX_CTRL, 8'h04);
      wr(URD_OFF_RATE_CTRL, 8'h08);
      wr(URD_OFF_DIV_HIGH, 8'h00);
      for (int k = 1; k <= 2; k++)
      begin
         wait_tick(gap);
         repeat (8) @(posedge clk);
         wr(k[3:0], (k == 1) ? 8'h03 : 8'h00);
         wait_tick(gap);
         check("restart delay", 16'(gap), 16'h0011);
      end
      // two back-to-back bytes, the second written once the first moved on
      wr(URD_OFF_RATE_CTRL, 8'h00);
      wr(URD_OFF_DIV_LOW, 8'h00);
      wr(URD_OFF_HOLDING, 8'h5a);
      wr(URD_OFF_TX_CTRL, 8'h24);
      for (int w = 0; w < 100 && irq !== 1'b1; w++) @(posedge clk);
      rd(URD_OFF_IRQ_STATUS);
      check("moved status", {8'h00, rd_val}, 16'h0001);
      rd(URD_OFF_TX_CTRL);
      check("shift busy", {8'h00, rd_val}, 16'h0024);
      wr(URD_OFF_HOLDING, 8'hc3);
      wr(URD_OFF_IRQ_STATUS, 8'h01);
      for (int w = 0; w < 2000 && peer.got.size() < 2; w++) @(posedge clk);
      check("frame count", 16'(peer.got.size()), 16'h0002);
      check("first frame", {7'h00, peer.got[0]}, 16'h005a);
      check("second frame", {7'h00, peer.got[1]}, 16'h00c3);
      // interrupt masked, unmasked, then cleared
      wr(URD_OFF_IRQ_MASK, 8'h00);
      repeat (2) @(negedge clk);
      check("irq masked", {15'h0000, irq}, 16'h0000);
      wr(URD_OFF_IRQ_MASK, 8'h03);
      repeat (2) @(negedge clk);
      check("irq raised", {15'h0000, irq}, 16'h0001);
      wr(URD_OFF_IRQ_STATUS, 8'h03);
      repeat (2) @(negedge clk);
      check("irq cleared", {15'h0000, irq}, 16'h0000);
      // nine-bit frame carries the ninth bit last
      nine <= 1'b1;
      wr(URD_OFF_TX_CTRL, 8'h65);
      wr(URD_OFF_HOLDING, 8'h65);
      for (int w = 0; w < 2000 && peer.got.size() < 3; w++) @(posedge clk);
      check("nine-bit frame", {7'h00, peer.got[2]}, 16'h0165);
      tally_and_finish;
   end

   // watchdog well beyond the expected run of about 12000 cycles
   initial
   begin
      #(50 * 80000);
      mismatches++;
      tally_and_finish;
   end
endmodule
